// ===== hw/reset_power_watchdog.sv
// Reset cause flags, watchdog, low-supply reset qualification and idle/power-down control.
// Assumes APB from a synchronous master, all inputs synchronous to pclk, and the watchdog
// RC oscillator delivered as a one-cycle tick per RC period.
//
// Summary of operation
// - Watchdog counts RC ticks in every mode.
// - Watchdog overflow causes a full system reset.
// - Overflow sets bit 7; software or power-on clears.
// - Any access to cause register restarts watchdog.
// - Three-bit select picks RC divisor per code.
// - Watchdog enable is a fixed strap option.
// - Power-on sets bit 5; only software clears.
// - Low-supply reset sets bit 4; software clears.
// - Pin reset sets bit 3; software clears.
// - Low supply must persist debounce time first.
// - Key 55 then idle bit enters idle.
// - Broken sequence clears unlock or mode bit.
// - Idle gates only the CPU clock.
// - Enabled interrupt ends idle, clears unlock, idle.
// - Any reset ends low power, clears mode state.
// - Key 55 then power-down bit enters power-down.
// - Power-down stops CPU and peripheral clocks.
// - Both bits set means power-down, both cleared.
// - External wake warms oscillator, then resumes.
// - Reset from power-down waits warm-up first.
// - Bits 3 and 2 are plain storage.
// - Warm-up is 128 RC or 4096 ceramic clocks.
`timescale 1ns/1ps

module reset_power_watchdog #(
  parameter int LVR_DEBOUNCE = sysctl_pkg::LVR_DEBOUNCE_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire sysctl_pkg::apb_req_t apb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire sysctl_pkg::strap_t straps,
  input wire logic wdog_rc_tick,
  input wire logic low_supply,
  input wire logic pin_reset_n,
  input wire logic wake_irq,
  input wire logic ext_wake,
  output sysctl_pkg::clk_gate_t clk_gate,
  output logic sys_reset
);
  import sysctl_pkg::*;

  // ==========================================================================
  // State
  // ==========================================================================
  pm_state_t state_q, state_d;
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d;
  logic pslverr_q, pslverr_d;
  logic wdog_ovf_flag_q, wdog_ovf_flag_d;
  logic power_on_flag_q, power_on_flag_d;
  logic low_supply_flag_q, low_supply_flag_d;
  logic pin_reset_flag_q, pin_reset_flag_d;
  logic [2:0] timeout_select_q, timeout_select_d;
  logic [3:0] power_control_q, power_control_d;
  logic [7:0] suspend_unlock_q, suspend_unlock_d;
  logic unlock_armed_q, unlock_armed_d;
  logic stray_mode_q, stray_mode_d;
  logic [WDOG_CNT_W-1:0] wdog_cnt_q, wdog_cnt_d;
  logic [15:0] lvr_cnt_q, lvr_cnt_d;
  logic lvr_qual_q, lvr_qual_d;
  logic [12:0] warm_cnt_q, warm_cnt_d;
  strap_t strap_q, strap_d;
  logic strap_taken_q, strap_taken_d;
  clk_gate_t clk_gate_q, clk_gate_d;
  logic sys_reset_q, sys_reset_d;

  // ==========================================================================
  // Bus decode
  // ==========================================================================
  logic access, wr, sel_cause, sel_pctl, sel_unlock, sel_status, mapped;
  logic [7:0] wbyte;
  logic [4:0] wdog_log2;
  logic [WDOG_CNT_W:0] wdog_span;
  logic [WDOG_CNT_W-1:0] wdog_mask;
  logic wdog_ovf, reset_evt, need_warm;
  logic [12:0] warm_last;
  logic [LVR_DEBOUNCE > 1 ? 15 : 15:0] lvr_last;

  // The access completes at the edge where the slave itself shows pready.
  assign access = apb.psel & apb.penable & pready_q;
  assign wr = access & apb.pwrite;
  assign wbyte = apb.pwdata[7:0];
  assign sel_cause = (apb.paddr == OFF_RESET_CAUSE);
  assign sel_pctl = (apb.paddr == OFF_POWER_CONTROL);
  assign sel_unlock = (apb.paddr == OFF_SUSPEND_UNLOCK);
  assign sel_status = (apb.paddr == OFF_STATUS);
  assign mapped = sel_cause | sel_pctl | sel_unlock | sel_status;

  // Watchdog terminal count from the selected divisor; code 101 is taken as 2^9.
  assign wdog_log2 = WDOG_LOG2[5 * int'(timeout_select_q) +: 5];
  assign wdog_span = (18'h00001 << wdog_log2) - 18'h00001;
  assign wdog_mask = wdog_span[WDOG_CNT_W-1:0];
  assign wdog_ovf = strap_taken_q & strap_q.wdog_enable & wdog_rc_tick
                    & (wdog_cnt_q == wdog_mask);

  // Any of the three sources forces a system reset.
  assign reset_evt = wdog_ovf | lvr_qual_q | ~pin_reset_n;
  // A watchdog reset from running needs no warm-up; pin, low supply or a stopped oscillator do.
  assign need_warm = lvr_qual_q | ~pin_reset_n | (state_q == ST_PDOWN)
                     | (state_q == ST_WAKE_WARM);
  assign warm_last = (strap_q.ceramic_osc ? WARM_CERAMIC_CLKS : WARM_RC_CLKS) - 13'h0001;
  assign lvr_last = 16'(LVR_DEBOUNCE - 1);

  // ==========================================================================
  // APB slave: one wait state, registered answer
  // ==========================================================================
  // Read data is sampled in the first access cycle so it stands with pready.
  always_comb begin
    pready_d = apb.psel & apb.penable & ~pready_q;
    pslverr_d = pready_d & ~mapped;
    prdata_d = prdata_q;
    if (pready_d) begin
      prdata_d = 32'h0000_0000;
      if (!apb.pwrite) begin
        if (sel_cause) begin
          prdata_d[BIT_WDOG_OVF] = wdog_ovf_flag_q;
          prdata_d[BIT_POWER_ON] = power_on_flag_q;
          prdata_d[BIT_LOW_SUPPLY] = low_supply_flag_q;
          prdata_d[BIT_PIN_RESET] = pin_reset_flag_q;
          prdata_d[TSEL_LSB +: 3] = timeout_select_q;
        end else if (sel_pctl) begin
          prdata_d[3:0] = power_control_q;
        end else if (sel_unlock) begin
          prdata_d[7:0] = suspend_unlock_q;
        end else if (sel_status) begin
          prdata_d[2:0] = state_q;
          prdata_d[3] = unlock_armed_q;
          prdata_d[4] = lvr_qual_q;
          prdata_d[5] = sys_reset_q;
          prdata_d[6] = strap_q.wdog_enable;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q <= prdata_d;
    end
  end

  // ==========================================================================
  // Straps, caught once after reset release
  // ==========================================================================
  // Options never change while running, so later strap movement is ignored.
  always_comb begin
    strap_d = strap_q;
    strap_taken_d = 1'b1;
    if (!strap_taken_q) begin
      strap_d = straps;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_q <= '0;
      strap_taken_q <= 1'b0;
    end else begin
      strap_q <= strap_d;
      strap_taken_q <= strap_taken_d;
    end
  end

  // ==========================================================================
  // Watchdog and low-supply debounce
  // ==========================================================================
  // The RC tick is not gated by any power mode, so the count survives power-down.
  always_comb begin
    wdog_cnt_d = wdog_cnt_q;
    if (!(strap_taken_q && strap_q.wdog_enable) || (access && sel_cause) || sys_reset_q) begin
      wdog_cnt_d = '0;
    end else if (wdog_rc_tick) begin
      wdog_cnt_d = (wdog_cnt_q == wdog_mask) ? '0 : wdog_cnt_q + 1'b1;
    end
    // A dip shorter than the debounce time never qualifies.
    lvr_cnt_d = lvr_cnt_q;
    lvr_qual_d = 1'b0;
    if (!(strap_taken_q && strap_q.lvr_enable && low_supply)) begin
      lvr_cnt_d = 16'h0000;
    end else if (lvr_cnt_q != lvr_last) begin
      lvr_cnt_d = lvr_cnt_q + 16'h0001;
    end else begin
      lvr_qual_d = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdog_cnt_q <= '0;
      lvr_cnt_q <= 16'h0000;
      lvr_qual_q <= 1'b0;
    end else begin
      wdog_cnt_q <= wdog_cnt_d;
      lvr_cnt_q <= lvr_cnt_d;
      lvr_qual_q <= lvr_qual_d;
    end
  end

  // ==========================================================================
  // Reset cause flags
  // ==========================================================================
  // Writing a zero clears a flag; a hardware set in the same cycle wins.
  always_comb begin
    logic wclr;
    wclr = wr & sel_cause;
    wdog_ovf_flag_d = wdog_ovf | (wdog_ovf_flag_q & ~(wclr & ~wbyte[BIT_WDOG_OVF]));
    power_on_flag_d = power_on_flag_q & ~(wclr & ~wbyte[BIT_POWER_ON]);
    low_supply_flag_d = lvr_qual_q
                        | (low_supply_flag_q & ~(wclr & ~wbyte[BIT_LOW_SUPPLY]));
    pin_reset_flag_d = ~pin_reset_n
                       | (pin_reset_flag_q & ~(wclr & ~wbyte[BIT_PIN_RESET]));
  end

  // Power-on is the asynchronous reset: it sets its own flag and clears the others.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdog_ovf_flag_q <= 1'b0;
      power_on_flag_q <= 1'b1;
      low_supply_flag_q <= 1'b0;
      pin_reset_flag_q <= 1'b0;
    end else begin
      wdog_ovf_flag_q <= wdog_ovf_flag_d;
      power_on_flag_q <= power_on_flag_d;
      low_supply_flag_q <= low_supply_flag_d;
      pin_reset_flag_q <= pin_reset_flag_d;
    end
  end

  // ==========================================================================
  // Control registers, unlock sequence and power-mode sequencer
  // ==========================================================================
  // Each completed APB transfer stands for one instruction of the unlock sequence.
  always_comb begin
    state_d = state_q;
    timeout_select_d = timeout_select_q;
    power_control_d = power_control_q;
    suspend_unlock_d = suspend_unlock_q;
    unlock_armed_d = unlock_armed_q;
    stray_mode_d = 1'b0;
    warm_cnt_d = warm_cnt_q;
    // A mode bit written without the key is dropped one cycle later.
    if (stray_mode_q) begin
      power_control_d[BIT_PDOWN] = 1'b0;
      power_control_d[BIT_IDLE] = 1'b0;
    end
    if (access) begin
      unlock_armed_d = 1'b0;
      if (unlock_armed_q && !(wr && sel_pctl)) begin
        suspend_unlock_d = 8'h00;
      end
      if (wr && sel_cause) begin
        timeout_select_d = wbyte[TSEL_LSB +: 3];
      end
      if (wr && sel_unlock) begin
        suspend_unlock_d = wbyte;
        unlock_armed_d = (wbyte == UNLOCK_KEY);
      end
      if (wr && sel_pctl) begin
        // Soft flags are plain storage with no effect on the sequencer.
        power_control_d = wbyte[3:0];
        if (wbyte[BIT_PDOWN] || wbyte[BIT_IDLE]) begin
          if (unlock_armed_q && state_q == ST_RUN) begin
            state_d = wbyte[BIT_PDOWN] ? ST_PDOWN : ST_IDLE;
          end else begin
            stray_mode_d = 1'b1;
          end
        end
      end
    end
    case (state_q)
      ST_RUN: begin
      end
      ST_IDLE: begin
        if (wake_irq) begin
          state_d = ST_RUN;
          suspend_unlock_d = 8'h00;
          power_control_d[BIT_IDLE] = 1'b0;
        end
      end
      ST_PDOWN: begin
        if (ext_wake) begin
          state_d = ST_WAKE_WARM;
          warm_cnt_d = 13'h0000;
        end
      end
      ST_WAKE_WARM: begin
        warm_cnt_d = warm_cnt_q + 13'h0001;
        if (warm_cnt_q == warm_last) begin
          state_d = ST_RUN;
          suspend_unlock_d = 8'h00;
          power_control_d[BIT_PDOWN] = 1'b0;
          power_control_d[BIT_IDLE] = 1'b0;
        end
      end
      ST_RESET_WARM: begin
        // Held while any source stays active, then the warm-up runs out.
        if (!reset_evt) begin
          warm_cnt_d = warm_cnt_q + 13'h0001;
          if (warm_cnt_q >= warm_last) begin
            state_d = ST_RUN;
          end
        end
      end
      default: begin
        state_d = ST_RUN;
      end
    endcase
    // Every reset source wins over the sequence above and clears mode state.
    if (reset_evt || state_d == ST_RESET_WARM) begin
      if (reset_evt && state_q != ST_RESET_WARM) begin
        warm_cnt_d = need_warm ? 13'h0000 : warm_last;
      end else if (reset_evt) begin
        warm_cnt_d = 13'h0000;
      end
      if (reset_evt) begin
        state_d = ST_RESET_WARM;
      end
      power_control_d = RST_POWER_CONTROL[3:0];
      suspend_unlock_d = RST_SUSPEND_UNLOCK;
      timeout_select_d = RST_TIMEOUT_SELECT;
      unlock_armed_d = 1'b0;
      stray_mode_d = 1'b0;
    end
  end

  // Clock gates and system reset follow the next state so they change with it.
  always_comb begin
    sys_reset_d = (state_d == ST_RESET_WARM);
    case (state_d)
      ST_RUN: clk_gate_d = '{cpu_clk_en: 1'b1, periph_clk_en: 1'b1, osc_en: 1'b1};
      ST_IDLE: clk_gate_d = '{cpu_clk_en: 1'b0, periph_clk_en: 1'b1, osc_en: 1'b1};
      ST_PDOWN: clk_gate_d = '{cpu_clk_en: 1'b0, periph_clk_en: 1'b0, osc_en: 1'b0};
      ST_WAKE_WARM: clk_gate_d = '{cpu_clk_en: 1'b0, periph_clk_en: 1'b0, osc_en: 1'b1};
      ST_RESET_WARM: clk_gate_d = '{cpu_clk_en: 1'b0, periph_clk_en: 1'b0, osc_en: 1'b1};
      default: clk_gate_d = '{cpu_clk_en: 1'b1, periph_clk_en: 1'b1, osc_en: 1'b1};
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_RUN;
      timeout_select_q <= RST_TIMEOUT_SELECT;
      power_control_q <= RST_POWER_CONTROL[3:0];
      suspend_unlock_q <= RST_SUSPEND_UNLOCK;
      unlock_armed_q <= 1'b0;
      stray_mode_q <= 1'b0;
      warm_cnt_q <= 13'h0000;
      clk_gate_q <= '{cpu_clk_en: 1'b1, periph_clk_en: 1'b1, osc_en: 1'b1};
      sys_reset_q <= 1'b0;
    end else begin
      state_q <= state_d;
      timeout_select_q <= timeout_select_d;
      power_control_q <= power_control_d;
      suspend_unlock_q <= suspend_unlock_d;
      unlock_armed_q <= unlock_armed_d;
      stray_mode_q <= stray_mode_d;
      warm_cnt_q <= warm_cnt_d;
      clk_gate_q <= clk_gate_d;
      sys_reset_q <= sys_reset_d;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign clk_gate = clk_gate_q;
  assign sys_reset = sys_reset_q;

endmodule : reset_power_watchdog

// ===== include/sysctl_pkg.sv
// Constants, state codes and carrier types for the reset, power and watchdog controller.
// Assumes a 200 MHz APB clock and 32-bit APB data with one register per aligned word.
package sysctl_pkg;

  // ==========================================================================
  // Register map and field layout
  // ==========================================================================
  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] OFF_RESET_CAUSE = 12'h000;
  localparam logic [ADDR_W-1:0] OFF_POWER_CONTROL = 12'h004;
  localparam logic [ADDR_W-1:0] OFF_SUSPEND_UNLOCK = 12'h008;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 12'h00c;
  localparam int BIT_WDOG_OVF = 7;
  localparam int BIT_POWER_ON = 5;
  localparam int BIT_LOW_SUPPLY = 4;
  localparam int BIT_PIN_RESET = 3;
  localparam int TSEL_LSB = 0;
  localparam int BIT_IDLE = 0;
  localparam int BIT_PDOWN = 1;
  localparam int BIT_SOFT0 = 2;
  localparam int BIT_SOFT1 = 3;

  // ==========================================================================
  // Reset values and keys
  // ==========================================================================
  localparam logic [7:0] RST_POWER_CONTROL = 8'h00;
  localparam logic [7:0] RST_SUSPEND_UNLOCK = 8'h00;
  localparam logic [2:0] RST_TIMEOUT_SELECT = 3'h0;
  localparam logic [7:0] UNLOCK_KEY = 8'h55;

  // ==========================================================================
  // Timing
  // ==========================================================================
  // Log2 of the watchdog divisor, five bits per code, code 0 in the low slice.
  localparam logic [39:0] WDOG_LOG2 = {5'h05, 5'h07, 5'h09, 5'h0b, 5'h0c, 5'h0d, 5'h0f, 5'h11};
  localparam int WDOG_CNT_W = 17;
  localparam logic [12:0] WARM_RC_CLKS = 13'h0080;
  localparam logic [12:0] WARM_CERAMIC_CLKS = 13'h1000;
  localparam int CLK_PERIOD_NS = 5;
  localparam int LVR_DEBOUNCE_NS = 30000;
  localparam int LVR_DEBOUNCE_CYCLES = (LVR_DEBOUNCE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef enum logic [2:0] {
    ST_RUN = 3'b000,
    ST_IDLE = 3'b001,
    ST_PDOWN = 3'b010,
    ST_WAKE_WARM = 3'b011,
    ST_RESET_WARM = 3'b100
  } pm_state_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic cpu_clk_en;
    logic periph_clk_en;
    logic osc_en;
  } clk_gate_t;

  typedef struct packed {
    logic wdog_enable;
    logic lvr_enable;
    logic ceramic_osc;
  } strap_t;

endpackage : sysctl_pkg

// ===== tb/reset_power_watchdog_asserts.sv
// Concurrent checks on the ports of the reset, power and watchdog controller.
// Assumes it is bound to reset_power_watchdog, with one clock pclk and reset presetn.
`timescale 1ns/1ps
module reset_power_watchdog_asserts #(
  parameter int LVR_DEBOUNCE = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire sysctl_pkg::apb_req_t apb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire sysctl_pkg::strap_t straps,
  input wire logic wdog_rc_tick,
  input wire logic low_supply,
  input wire logic pin_reset_n,
  input wire logic wake_irq,
  input wire logic ext_wake,
  input wire sysctl_pkg::clk_gate_t clk_gate,
  input wire logic sys_reset
);
  import sysctl_pkg::*;
  // ==========================================================================
  // Helper counters
  // ==========================================================================
  logic [12:0] warm_q;
  logic [12:0] warm_d;
  logic [15:0] dip_q;
  logic [15:0] dip_d;
  int warm_len;
  // Warm cycles and low-supply cycles; the dip count saturates so a long brown-out never wraps.
  always_comb begin
    warm_d = (clk_gate == 3'b001 && !sys_reset) ? warm_q + 13'h1 : 13'h0;
    dip_d = (low_supply && straps.lvr_enable) ? dip_q + {15'h0, ~&dip_q} : 16'h0;
    warm_len = straps.ceramic_osc ? 4096 : 128;
  end
  // Registers of the helper counters.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      warm_q <= 13'h0;
      dip_q <= 16'h0;
    end else begin
      warm_q <= warm_d;
      dip_q <= dip_d;
    end
  end
  // ==========================================================================
  // Properties
  // ==========================================================================
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup; apb.psel && !apb.penable; endsequence
  sequence s_access; apb.psel && apb.penable; endsequence
  sequence s_warming; (clk_gate == 3'b001)[*8]; endsequence
  property p_apb_wait; s_setup ##1 s_access |=> pready; endproperty
  property p_ready_pulse; pready |=> !pready; endproperty
  property p_err_zero; pslverr |-> pready && prdata == 32'h0; endproperty
  property p_idle_wake;
    clk_gate == 3'b011 && wake_irq && pin_reset_n && !low_supply && !sys_reset |=> clk_gate == 3'b111;
  endproperty
  property p_pdown_wake; clk_gate == 3'b000 && ext_wake && pin_reset_n && !low_supply |=> s_warming; endproperty
  property p_warm_len;
    $rose(clk_gate.cpu_clk_en) && warm_q > 13'h010 |-> warm_q >= warm_len - 2 && warm_q <= warm_len + 2;
  endproperty
  property p_reset_gates; $rose(sys_reset) |-> clk_gate == 3'b001; endproperty
  property p_pin_reset; !pin_reset_n |=> sys_reset; endproperty
  property p_dip_late; dip_q == 16'(LVR_DEBOUNCE + 3) |-> sys_reset; endproperty
  a_apb_wait: assert property (p_apb_wait) else $error("pready not in second access cycle");
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready held two cycles");
  a_err_zero: assert property (p_err_zero) else $error("pslverr without pready or with data");
  a_idle_wake: assert property (p_idle_wake)
    else $error("interrupt did not end idle");
  a_pdown_wake: assert property (p_pdown_wake)
    else $error("wake from power-down skipped the oscillator warm-up");
  a_warm_len: assert property (p_warm_len)
    else $error("warm-up length wrong");
  a_reset_gates: assert property (p_reset_gates)
    else $error("reset did not hold CPU and peripheral clocks");
  a_pin_reset: assert property (p_pin_reset)
    else $error("pin reset not followed by system reset");
  a_dip_late: assert property (p_dip_late)
    else $error("persistent low supply gave no reset");
endmodule : reset_power_watchdog_asserts

// ===== tb/tb_reset_power_watchdog.sv
// Self-checking bench for the reset, power and watchdog controller against a register model.
// Assumes the package, the design and the checker are compiled before this file.
`timescale 1ns/1ps
module tb_reset_power_watchdog;
  import sysctl_pkg::*;
  localparam int DEB = 8;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  apb_req_t apb = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  strap_t straps = 3'b110;
  logic wdog_rc_tick = 1'b0;
  logic low_supply = 1'b0;
  logic pin_reset_n = 1'b1;
  logic wake_irq = 1'b0;
  logic ext_wake = 1'b0;
  clk_gate_t clk_gate;
  logic sys_reset;
  int bad_count = 0;
  int num_checks = 0;
  integer seed = 32'h201148b3;
  logic [7:0] m_flags = 8'h20;
  logic [2:0] m_tsel = 3'h0;
  logic [3:0] m_power_control = 4'h0;
  logic [31:0] r;
  logic e;
  int n;
  int k;
  // ==========================================================================
  // Clock, design and helpers
  // ==========================================================================
  always #2.5 pclk = ~pclk;
  reset_power_watchdog #(.LVR_DEBOUNCE(DEB)) i_dut (.pclk(pclk), .presetn(presetn), .apb(apb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .straps(straps), .wdog_rc_tick(wdog_rc_tick),
    .low_supply(low_supply), .pin_reset_n(pin_reset_n), .wake_irq(wake_irq), .ext_wake(ext_wake),
    .clk_gate(clk_gate), .sys_reset(sys_reset));
  // Compare one value and count it.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // One APB transfer; an idle cycle follows so the request is never driven twice in one step.
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int w;
    w = 0;
    apb <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge pclk);
    apb.penable <= 1'b1;
    do begin
      @(posedge pclk);
      w++;
    end while (pready !== 1'b1 && w < 50);
    chk(pready, 1'b1);
    r = prdata;
    e = pslverr;
    apb <= '0;
    @(posedge pclk);
  endtask : xfer
  // Register write with random upper bits, which the design must ignore; the model follows.
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    xfer(1'b1, a, ({$random(seed)} & 32'hffffff00) | {24'h0, d});
    if (a == OFF_RESET_CAUSE) begin
      m_flags = m_flags & d & 8'hb8;
      m_tsel = d[2:0];
    end
    if (a == OFF_POWER_CONTROL) m_power_control = {d[3:2], 2'b00};
  endtask : wr
  // Register read compared with the model.
  task automatic rd(input logic [11:0] a);
    xfer(1'b0, a, 32'h0);
    chk(e, 1'b0);
    chk(r, (a == OFF_RESET_CAUSE) ? {24'h0, m_flags | {5'h0, m_tsel}} :
      (a == OFF_POWER_CONTROL) ? {28'h0, m_power_control} : 32'h0);
  endtask : rd
  // A system reset sets a cause flag and clears mode state and the timeout code.
  task automatic hw_reset(input logic [7:0] f);
    m_flags = m_flags | f;
    m_power_control = 4'h0;
    m_tsel = 3'h0;
  endtask : hw_reset
  // Watchdog ticks two cycles apart; k is the tick at which reset showed, or -1.
  task automatic ticks(input int num);
    k = -1;
    for (int i = 1; i <= num && k < 0; i++) begin
      wdog_rc_tick <= 1'b1;
      @(posedge pclk);
      wdog_rc_tick <= 1'b0;
      @(posedge pclk);
      if (sys_reset === 1'b1) k = i;
    end
  endtask : ticks
  // Bounded wait until the CPU clock runs again out of reset; n holds the cycles waited.
  task automatic wait_cpu();
    n = 0;
    while ((clk_gate.cpu_clk_en !== 1'b1 || sys_reset !== 1'b0) && n < 6000) begin
      @(posedge pclk);
      n++;
    end
    chk(n < 6000, 1'b1);
  endtask : wait_cpu
  task automatic print_verdict();
    $display("Checks %0d, mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : print_verdict
  // ==========================================================================
  // Tests
  // ==========================================================================
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(OFF_RESET_CAUSE);
    rd(OFF_POWER_CONTROL);
    xfer(1'b0, 12'h010, 32'h0);
    chk(e, 1'b1);
    for (int c = 0; c < 8; c++) begin
      wr(OFF_RESET_CAUSE, 8'(c));
      rd(OFF_RESET_CAUSE);
    end
    for (int c = 0; c < 4; c++) begin
      wr(OFF_POWER_CONTROL, 8'($random(seed)) & 8'h0c);
      rd(OFF_POWER_CONTROL);
      chk(clk_gate, 3'b111);
    end
    $display("Test registers finished");
    // A mode bit without the key, and a key broken by another transfer, must both be undone.
    wr(OFF_POWER_CONTROL, 8'h0d);
    repeat (3) @(posedge pclk);
    chk(clk_gate, 3'b111);
    rd(OFF_POWER_CONTROL);
    wr(OFF_SUSPEND_UNLOCK, 8'h55);
    rd(OFF_POWER_CONTROL);
    rd(OFF_SUSPEND_UNLOCK);
    wr(OFF_POWER_CONTROL, 8'h01);
    repeat (3) @(posedge pclk);
    chk(clk_gate, 3'b111);
    $display("Test broken key finished");
    wr(OFF_SUSPEND_UNLOCK, 8'h55);
    wr(OFF_POWER_CONTROL, 8'h01);
    repeat (5) @(posedge pclk);
    chk(clk_gate, 3'b011);
    wake_irq <= 1'b1;
    repeat (2) @(posedge pclk);
    wake_irq <= 1'b0;
    chk(clk_gate, 3'b111);
    rd(OFF_POWER_CONTROL);
    rd(OFF_SUSPEND_UNLOCK);
    $display("Test idle finished");
    wr(OFF_SUSPEND_UNLOCK, 8'h55);
    wr(OFF_POWER_CONTROL, 8'h03);
    repeat (20) @(posedge pclk);
    chk(clk_gate, 3'b000);
    ext_wake <= 1'b1;
    wait_cpu();
    ext_wake <= 1'b0;
    chk(n >= 126 && n <= 134, 1'b1);
    rd(OFF_POWER_CONTROL);
    rd(OFF_SUSPEND_UNLOCK);
    $display("Test power-down finished");
    // Shortest timeout code: accesses restart the count, silence lets it overflow.
    wr(OFF_RESET_CAUSE, 8'h07);
    ticks(30);
    rd(OFF_RESET_CAUSE);
    ticks(30);
    chk(k, -1);
    rd(OFF_RESET_CAUSE);
    ticks(40);
    chk(k >= 30 && k <= 34, 1'b1);
    wait_cpu();
    hw_reset(8'h80);
    rd(OFF_RESET_CAUSE);
    $display("Test watchdog finished");
    wr(OFF_SUSPEND_UNLOCK, 8'h55);
    wr(OFF_POWER_CONTROL, 8'h02);
    repeat (5) @(posedge pclk);
    pin_reset_n <= 1'b0;
    repeat (4) @(posedge pclk);
    chk(sys_reset, 1'b1);
    pin_reset_n <= 1'b1;
    wait_cpu();
    chk(n >= 126 && n <= 140, 1'b1);
    hw_reset(8'h08);
    rd(OFF_RESET_CAUSE);
    rd(OFF_POWER_CONTROL);
    wr(OFF_RESET_CAUSE, 8'h00);
    $display("Test pin reset finished");
    low_supply <= 1'b1;
    repeat (DEB - 3) @(posedge pclk);
    low_supply <= 1'b0;
    repeat (10) @(posedge pclk);
    chk(sys_reset, 1'b0);
    low_supply <= 1'b1;
    repeat (DEB + 4) @(posedge pclk);
    chk(sys_reset, 1'b1);
    low_supply <= 1'b0;
    wait_cpu();
    hw_reset(8'h10);
    rd(OFF_RESET_CAUSE);
    // Mid-run power-on reset leaves only the power-on flag.
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    m_flags = 8'h20;
    rd(OFF_RESET_CAUSE);
    $display("Test low supply finished");
    print_verdict();
  end
  // Cuts a hang short; the whole run needs well under a tenth of this span.
  initial begin
    #100000;
    bad_count++;
    $display("Error at %0t: run timed out", $time);
    print_verdict();
  end
endmodule : tb_reset_power_watchdog
bind reset_power_watchdog reset_power_watchdog_asserts #(.LVR_DEBOUNCE(LVR_DEBOUNCE)) i_chk (.pclk(pclk),
  .presetn(presetn), .apb(apb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .straps(straps),
  .wdog_rc_tick(wdog_rc_tick), .low_supply(low_supply), .pin_reset_n(pin_reset_n), .wake_irq(wake_irq),
  .ext_wake(ext_wake), .clk_gate(clk_gate), .sys_reset(sys_reset));
